// *** rtl/motor_pwm_map.svh ***
`ifndef MOTOR_PWM_MAP_SVH
`define MOTOR_PWM_MAP_SVH
// ====================
// Register offsets (word index on the register port).
`define REG_TB_CONTROL 4'h0
`define REG_TB_COUNTER 4'h1
`define REG_TB_PERIOD 4'h2
`define REG_SEVT_COMPARE 4'h3
`define REG_PAIR_CONTROL 4'h4
`define REG_UPDATE_CONTROL 4'h5
`define REG_DUTY_FIRST 4'h6
`define REG_DUTY_LAST 4'h9
`define REG_OVERRIDE 4'ha
`define REG_FAULT_CONTROL 4'hb
`define REG_STATUS 4'hc
// ====================
// Field positions.
`define TBC_ENABLE_BIT 15
`define TBC_IDLE_STOP_BIT 13
`define TBC_POSTSCALE_LSB 4
`define TBC_PRESCALE_LSB 2
`define TBC_MODE_LSB 0
`define DIR_BIT 15
`define PAIR_MODE_LSB 8
`define PAIR_HIGH_EN_LSB 4
`define PAIR_LOW_EN_LSB 0
`define UPD_SEVT_POST_LSB 8
`define UPD_IMMEDIATE_BIT 2
`define UPD_DISABLE_BIT 0
`define OVR_VALUE_LSB 8
`define OVR_ENABLE_LSB 0
`define FLT_STATE_LSB 8
`define FLT_ENABLE_LSB 0
// ====================
// Reset values and prescaler terminal counts.
`define RESET_WORD 16'h0000
`define PRESCALE_TC_1 6'h00
`define PRESCALE_TC_4 6'h03
`define PRESCALE_TC_16 6'h0f
`define PRESCALE_TC_64 6'h3f
`endif

// *** rtl/motor_pwm_pkg.sv ***
`default_nettype none
package motor_pwm_pkg;
   // Time base operating modes.
   typedef enum logic [1:0] {
      MODE_FREE_RUN = 2'h0,
      MODE_SINGLE_PULSE = 2'h1,
      MODE_UP_DOWN = 2'h2,
      MODE_UP_DOWN_DOUBLE = 2'h3
   } time_base_mode_t;
   // Time base input clock prescale selections.
   typedef enum logic [1:0] {
      PRESCALE_1 = 2'h0,
      PRESCALE_4 = 2'h1,
      PRESCALE_16 = 2'h2,
      PRESCALE_64 = 2'h3
   } time_base_prescale_t;
endpackage : motor_pwm_pkg
`default_nettype wire

// *** rtl/motor_pwm_time_base.sv ***
// Functional notes
// - Four duty generators drive four output pairs.
// - Complementary pair: low is inverse of high.
// - Duty values are up to 16 bits.
// - Period may change while running.
// - Edge-aligned up count; center-aligned up/down.
// - Single-pulse mode runs once then stops.
// - Center mode events at period and zero; MODE_UP_DOWN gives zero only, MODE_UP_DOWN_DOUBLE gives both.
// - Software override replaces generated output state.
// - Enabled fault drives outputs to programmed state.
// - Duty updates immediate or at boundary.
// - Special-event comparator triggers other peripherals.
// - Counter bit 15 shows direction, read-only.
// - Counter bits 14-0 readable and writable.
// - Period is bits 14-0; bit 15 zero.
// - Trigger when count equals compare value.
// - Trigger also needs matching direction bit.
// - Four-bit postscaler, 0000 1:1, 0001 1:2.
// - Output enable reset follows configuration strap.
//
// Added by the designer: strobed register access and the register offsets.
`include "motor_pwm_map.svh"
`default_nettype none
module motor_pwm_time_base
   import motor_pwm_pkg::*;
#(
   parameter int PAIRS = 4,
   parameter int COUNT_W = 15,
   parameter int DUTY_W = 16
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic cpu_idle,
   input wire logic fault_in_n,
   input wire logic pin_enable_strap,
   output logic [PAIRS-1:0] high_output,
   output logic [PAIRS-1:0] low_output,
   output logic [PAIRS-1:0] high_output_oe_n,
   output logic [PAIRS-1:0] low_output_oe_n,
   output logic period_event,
   output logic special_event_trigger
);
   // ====================
   // Elaboration checks
   initial begin
      if (PAIRS != 4) $error("four pairs only");
      if (COUNT_W != 15) $error("count width 15");
      if (DUTY_W < 1 || DUTY_W > 16) $error("duty width 1..16");
   end

   // ====================
   // Declarations
   logic tb_enable;
   logic idle_stop;
   logic [3:0] postscale;
   time_base_prescale_t prescale;
   time_base_mode_t mode;
   logic [COUNT_W-1:0] count;
   logic count_direction;
   logic [COUNT_W-1:0] period_value;
   logic special_event_direction;
   logic [COUNT_W-1:0] special_event_compare_value;
   logic [PAIRS-1:0] pair_independent_select;
   logic [PAIRS-1:0] high_output_enable;
   logic [PAIRS-1:0] low_output_enable;
   logic [3:0] sevt_postscale;
   logic immediate_update;
   logic update_disable;
   logic [2*PAIRS-1:0] override_value;
   logic [2*PAIRS-1:0] override_enable;
   logic [2*PAIRS-1:0] fault_state;
   logic [PAIRS-1:0] fault_enable;
   logic [DUTY_W-1:0] duty_buffer [PAIRS];
   logic [DUTY_W-1:0] duty_active [PAIRS];
   logic [5:0] pre_count;
   logic [5:0] pre_limit;
   logic [3:0] post_count;
   logic [3:0] sevt_post_count;
   logic fault_meta;
   logic fault_sync_n;
   logic strap_meta;
   logic strap_sync;
   logic running;
   logic tick;
   logic at_period;
   logic boundary;
   logic single_done;
   logic sevt_match;
   logic [PAIRS-1:0] pair_fault;
   logic [PAIRS-1:0] pair_high;
   logic [PAIRS-1:0] pair_low;
   logic wr_ctl;
   logic wr_cnt;
   logic [15:0] next_rdata;

   assign wr_ctl = reg_wr && (reg_addr == `REG_TB_CONTROL);
   assign wr_cnt = reg_wr && (reg_addr == `REG_TB_COUNTER);

   // ====================
   // Pin synchronisers
   // Fault pin and enable strap each pass two flip-flops.
   always_ff @(posedge mclk) begin
      fault_meta <= fault_in_n;
      fault_sync_n <= fault_meta;
      strap_meta <= pin_enable_strap;
      strap_sync <= strap_meta;
   end

   // ====================
   // Time base control
   // Software write wins over the single-pulse self clear.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tb_enable <= 1'b0;
         idle_stop <= 1'b0;
         postscale <= 4'h0;
         prescale <= PRESCALE_1;
         mode <= MODE_FREE_RUN;
      end else if (wr_ctl) begin
         tb_enable <= reg_wdata[`TBC_ENABLE_BIT];
         idle_stop <= reg_wdata[`TBC_IDLE_STOP_BIT];
         postscale <= reg_wdata[`TBC_POSTSCALE_LSB +: 4];
         prescale <= time_base_prescale_t'(reg_wdata[`TBC_PRESCALE_LSB +: 2]);
         mode <= time_base_mode_t'(reg_wdata[`TBC_MODE_LSB +: 2]);
      end else if (single_done) begin
         tb_enable <= 1'b0;
      end
   end

   // Remaining software registers.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         period_value <= '0;
         special_event_direction <= 1'b0;
         special_event_compare_value <= '0;
         pair_independent_select <= '0;
         high_output_enable <= strap_sync ? 4'hf : 4'h0;
         low_output_enable <= strap_sync ? 4'hf : 4'h0;
         sevt_postscale <= 4'h0;
         immediate_update <= 1'b0;
         update_disable <= 1'b0;
         override_value <= '0;
         override_enable <= '0;
         fault_state <= '0;
         fault_enable <= '0;
      end else if (reg_wr) begin
         case (reg_addr)
            `REG_TB_PERIOD: begin
               period_value <= reg_wdata[COUNT_W-1:0];
            end
            `REG_SEVT_COMPARE: begin
               special_event_direction <= reg_wdata[`DIR_BIT];
               special_event_compare_value <= reg_wdata[COUNT_W-1:0];
            end
            `REG_PAIR_CONTROL: begin
               pair_independent_select <= reg_wdata[`PAIR_MODE_LSB +: 4];
               high_output_enable <= reg_wdata[`PAIR_HIGH_EN_LSB +: 4];
               low_output_enable <= reg_wdata[`PAIR_LOW_EN_LSB +: 4];
            end
            `REG_UPDATE_CONTROL: begin
               sevt_postscale <= reg_wdata[`UPD_SEVT_POST_LSB +: 4];
               immediate_update <= reg_wdata[`UPD_IMMEDIATE_BIT];
               update_disable <= reg_wdata[`UPD_DISABLE_BIT];
            end
            `REG_OVERRIDE: begin
               override_value <= reg_wdata[`OVR_VALUE_LSB +: 8];
               override_enable <= reg_wdata[`OVR_ENABLE_LSB +: 8];
            end
            `REG_FAULT_CONTROL: begin
               fault_state <= reg_wdata[`FLT_STATE_LSB +: 8];
               fault_enable <= reg_wdata[`FLT_ENABLE_LSB +: 4];
            end
            default: begin
            end
         endcase
      end
   end

   // ====================
   // Prescaler
   // Select the terminal count of the input clock divider.
   always_comb begin
      case (prescale)
         PRESCALE_1: pre_limit = `PRESCALE_TC_1;
         PRESCALE_4: pre_limit = `PRESCALE_TC_4;
         PRESCALE_16: pre_limit = `PRESCALE_TC_16;
         PRESCALE_64: pre_limit = `PRESCALE_TC_64;
         default: pre_limit = `PRESCALE_TC_1;
      endcase
   end

   assign running = tb_enable && !(cpu_idle && idle_stop);
   assign tick = running && (pre_count == pre_limit);

   // The divider restarts whenever the time base is held.
   always_ff @(posedge mclk) begin
      if (!rst_n || !running || tick) begin
         pre_count <= 6'h00;
      end else begin
         pre_count <= pre_count + 6'h01;
      end
   end

   // ====================
   // Time base counter
   // A count at or past the period wraps in edge modes and turns down in center modes, so a shrunken period never runs away.
   assign at_period = (count >= period_value);
   assign single_done = tick && (mode == MODE_SINGLE_PULSE) && at_period;

   // Boundary events: period in edge modes, zero and optionally period in center modes.
   always_comb begin
      boundary = 1'b0;
      if (tick) begin
         case (mode)
            MODE_FREE_RUN: boundary = at_period;
            MODE_SINGLE_PULSE: boundary = at_period;
            MODE_UP_DOWN: boundary = count_direction && (count == '0);
            MODE_UP_DOWN_DOUBLE: begin
               boundary = count_direction ? (count == '0) : at_period;
            end
            default: boundary = 1'b0;
         endcase
      end
   end

   // Count up, or up then down, at each prescaled tick.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         count <= '0;
         count_direction <= 1'b0;
      end else if (wr_cnt) begin
         count <= reg_wdata[COUNT_W-1:0];
      end else if (tick) begin
         case (mode)
            MODE_FREE_RUN, MODE_SINGLE_PULSE: begin
               count_direction <= 1'b0;
               count <= at_period ? '0 : count + 1'b1;
            end
            MODE_UP_DOWN, MODE_UP_DOWN_DOUBLE: begin
               if (!count_direction && at_period) begin
                  count_direction <= 1'b1;
                  count <= count - 1'b1;
               end else if (count_direction && count == '0) begin
                  count_direction <= 1'b0;
                  count <= count + 1'b1;
               end else if (count_direction) begin
                  count <= count - 1'b1;
               end else begin
                  count <= count + 1'b1;
               end
            end
            default: begin
               count <= '0;
            end
         endcase
      end
   end

   // ====================
   // Output event postscaler
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         post_count <= 4'h0;
         period_event <= 1'b0;
      end else begin
         period_event <= 1'b0;
         if (boundary) begin
            if (post_count == postscale) begin
               post_count <= 4'h0;
               period_event <= 1'b1;
            end else begin
               post_count <= post_count + 4'h1;
            end
         end
      end
   end

   // ====================
   // Special-event comparator
   assign sevt_match = tick && (count == special_event_compare_value) &&
      (count_direction == special_event_direction);

   // Postscaled one-cycle trigger toward other peripherals.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sevt_post_count <= 4'h0;
         special_event_trigger <= 1'b0;
      end else begin
         special_event_trigger <= 1'b0;
         if (sevt_match) begin
            if (sevt_post_count == sevt_postscale) begin
               sevt_post_count <= 4'h0;
               special_event_trigger <= 1'b1;
            end else begin
               sevt_post_count <= sevt_post_count + 4'h1;
            end
         end
      end
   end

   // ====================
   // Duty generators and pair outputs
   assign pair_fault = fault_enable & {PAIRS{~fault_sync_n}};

   for (genvar i = 0; i < PAIRS; i++) begin : g_pair
      // Buffered duty written by software.
      always_ff @(posedge mclk) begin
         if (!rst_n) begin
            duty_buffer[i] <= '0;
         end else if (reg_wr && reg_addr == 4'(`REG_DUTY_FIRST + i)) begin
            duty_buffer[i] <= reg_wdata[DUTY_W-1:0];
         end
      end

      // Active duty follows at once or at the boundary.
      always_ff @(posedge mclk) begin
         if (!rst_n) begin
            duty_active[i] <= '0;
         end else if (immediate_update || (boundary && !update_disable)) begin
            duty_active[i] <= duty_buffer[i];
         end
      end

      pwm_pair_stage #(
         .COUNT_W(COUNT_W),
         .DUTY_W(DUTY_W)
      ) u_stage (
         .mclk(mclk),
         .rst_n(rst_n),
         .count(count),
         .duty(duty_active[i]),
         .pair_independent_select(pair_independent_select[i]),
         .fault_active(pair_fault[i]),
         .fault_state(fault_state[2*i +: 2]),
         .override_en(override_enable[2*i +: 2]),
         .override_val(override_value[2*i +: 2]),
         .high_output(pair_high[i]),
         .low_output(pair_low[i])
      );

      // A released pin is handed to general I/O and driven low here.
      assign high_output[i] = pair_high[i] & high_output_enable[i];
      assign low_output[i] = pair_low[i] & low_output_enable[i];
      assign high_output_oe_n[i] = ~high_output_enable[i];
      assign low_output_oe_n[i] = ~low_output_enable[i];
   end

   // ====================
   // Register read port
   // Read data are selected here and registered for the next cycle.
   always_comb begin
      next_rdata = `RESET_WORD;
      case (reg_addr)
         `REG_TB_CONTROL: begin
            next_rdata[`TBC_ENABLE_BIT] = tb_enable;
            next_rdata[`TBC_IDLE_STOP_BIT] = idle_stop;
            next_rdata[`TBC_POSTSCALE_LSB +: 4] = postscale;
            next_rdata[`TBC_PRESCALE_LSB +: 2] = prescale;
            next_rdata[`TBC_MODE_LSB +: 2] = mode;
         end
         `REG_TB_COUNTER: next_rdata = {count_direction, count};
         `REG_TB_PERIOD: next_rdata = {1'b0, period_value};
         `REG_SEVT_COMPARE: begin
            next_rdata = {special_event_direction, special_event_compare_value};
         end
         `REG_PAIR_CONTROL: begin
            next_rdata[`PAIR_MODE_LSB +: 4] = pair_independent_select;
            next_rdata[`PAIR_HIGH_EN_LSB +: 4] = high_output_enable;
            next_rdata[`PAIR_LOW_EN_LSB +: 4] = low_output_enable;
         end
         `REG_UPDATE_CONTROL: begin
            next_rdata[`UPD_SEVT_POST_LSB +: 4] = sevt_postscale;
            next_rdata[`UPD_IMMEDIATE_BIT] = immediate_update;
            next_rdata[`UPD_DISABLE_BIT] = update_disable;
         end
         `REG_OVERRIDE: next_rdata = {override_value, override_enable};
         `REG_FAULT_CONTROL: next_rdata = {fault_state, 4'h0, fault_enable};
         `REG_STATUS: next_rdata = {8'h00, pair_fault, 2'h0, running, ~fault_sync_n};
         default: begin
            if (reg_addr >= `REG_DUTY_FIRST && reg_addr <= `REG_DUTY_LAST) begin
               next_rdata[DUTY_W-1:0] = duty_buffer[2'(reg_addr - `REG_DUTY_FIRST)];
            end
         end
      endcase
   end

   // Read data stand only in the cycle after the read strobe.
   always_ff @(posedge mclk) begin
      if (!rst_n || !reg_rd) begin
         reg_rdata <= `RESET_WORD;
      end else begin
         reg_rdata <= next_rdata;
      end
   end
endmodule : motor_pwm_time_base
`default_nettype wire

// *** rtl/pwm_pair_stage.sv ***
`default_nettype none
module pwm_pair_stage
   import motor_pwm_pkg::*;
#(
   parameter int COUNT_W = 15,
   parameter int DUTY_W = 16
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [COUNT_W-1:0] count,
   input wire logic [DUTY_W-1:0] duty,
   input wire logic pair_independent_select,
   input wire logic fault_active,
   input wire logic [1:0] fault_state,
   input wire logic [1:0] override_en,
   input wire logic [1:0] override_val,
   output logic high_output,
   output logic low_output
);
   initial begin
      if (DUTY_W < COUNT_W) $error("duty narrower than count");
   end

   logic pwm_raw;
   logic next_high;
   logic next_low;

   // Compare the time base with the duty value.
   assign pwm_raw = (DUTY_W'(count) < duty);

   // Fault state wins over override, and override over the waveform.
   always_comb begin
      next_high = pwm_raw;
      next_low = pair_independent_select ? pwm_raw : ~pwm_raw;
      if (override_en[1]) next_high = override_val[1];
      if (override_en[0]) next_low = override_val[0];
      if (fault_active) begin
         next_high = fault_state[1];
         next_low = fault_state[0];
      end
   end

   // Registered pair outputs.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         high_output <= 1'b0;
         low_output <= 1'b0;
      end else begin
         high_output <= next_high;
         low_output <= next_low;
      end
   end
endmodule : pwm_pair_stage
`default_nettype wire

// *** sim/motor_pwm_time_base_test.sv ***
`default_nettype none
module motor_pwm_time_base_test
   import motor_pwm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ====================
   // Bench signals and the block under test.
   logic mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, fault_cmd = 1'b0;
   logic period_event, special_event_trigger, fault_in_n, dn;
   logic [3:0] reg_addr = 4'h0, pm, high_output, low_output, high_output_oe_n, low_output_oe_n;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, q, d;
   int seed = 32'h8f99, bad_count = 0, comparisons = 0, cyc = 0, g, n, hi[4], lo[4], du[4];
   motor_pwm_time_base dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .cpu_idle(1'b0), .fault_in_n(fault_in_n), .pin_enable_strap(1'b1),
      .high_output(high_output), .low_output(low_output), .high_output_oe_n(high_output_oe_n),
      .low_output_oe_n(low_output_oe_n), .period_event(period_event),
      .special_event_trigger(special_event_trigger));
   power_stage_model stage (.fault_cmd(fault_cmd), .fault_in_n(fault_in_n));
   // The clock toggles every half period of 2.5 ns.
   always #2.5 mclk = ~mclk;
   // A hung run is cut short and counted as a mismatch.
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 60000) begin
         bad_count++;
         give_verdict();
      end
   end
   // Readback expected after a write.
   function automatic logic [15:0] rw_exp(input int a, input logic [15:0] v);
      case (a)
         0: rw_exp = v & 16'h20ff;
         1, 2: rw_exp = v & 16'h7fff;
         3, 6, 7, 8, 9, 10: rw_exp = v;
         4: rw_exp = v & 16'h0fff;
         5: rw_exp = v & 16'h0f05;
         11: rw_exp = v & 16'hff0f;
         default: rw_exp = 16'h0000;
      endcase
   endfunction : rw_exp
   function automatic logic [3:0] hb(input logic [7:0] x);
      hb = {x[7], x[5], x[3], x[1]};
   endfunction : hb
   function automatic logic [3:0] lb(input logic [7:0] x);
      lb = {x[6], x[4], x[2], x[0]};
   endfunction : lb
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
      v = reg_rdata;
   endtask : rd
   // Stop, clear, set the period and start.
   task automatic cfg(input logic [15:0] c, input logic [15:0] p);
      wr(4'h0, 16'h0000);
      wr(4'h1, 16'h0000);
      wr(4'h2, p);
      wr(4'h0, c);
   endtask : cfg
   // Cycles between two events, with high cycles per output.
   task automatic ev_gap(input bit sel);
      int w;
      w = 0;
      g = 0;
      hi = '{default: 0};
      lo = '{default: 0};
      @(negedge mclk);
      while ((sel ? special_event_trigger : period_event) !== 1'b1 && w < 3000) begin
         @(negedge mclk);
         w++;
      end
      do begin
         @(negedge mclk);
         g++;
         for (int p = 0; p < 4; p++) begin
            hi[p] += int'(high_output[p]);
            lo[p] += int'(low_output[p]);
         end
      end while ((sel ? special_event_trigger : period_event) !== 1'b1 && g < 3000);
   endtask : ev_gap
   task automatic give_verdict;
      if (bad_count == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : give_verdict
   // Main sequence.
   initial begin
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      for (int a = 0; a < 16; a++) begin
         rd(4'(a), q);
         chk(q, (a == 4) ? 16'h00ff : 16'h0000);
      end
      for (int a = 0; a < 16; a++) begin
         d = 16'($random(seed));
         wr(4'(a), (a == 0) ? (d & 16'h7fff) : d);
         rd(4'(a), q);
         chk(q, rw_exp(a, d));
      end
      wr(4'ha, 16'h0000);
      wr(4'hb, 16'h0000);
      wr(4'h4, 16'h00ff);
      wr(4'h5, 16'h0004);
      for (int i = 0; i < 20; i++) begin
         cfg(16'(i < 4 ? 16'h8000 | (i << 2) : 16'h8000 | ((i - 4) << 4)), 16'h0003);
         ev_gap(1'b0);
         chk(16'(g), 16'(i < 4 ? 4 << (2 * i) : 4 * (i - 3)));
      end
      cfg(16'h8002, 16'h0005);
      ev_gap(1'b0);
      chk(16'(g), 16'h000a);
      cfg(16'h8003, 16'h0005);
      ev_gap(1'b0);
      chk(16'(g), 16'h0005);
      cfg(16'h8001, 16'h0005);
      repeat (20) @(negedge mclk);
      rd(4'h0, q);
      chk(q, 16'h0001);
      for (int m = 0; m < 2; m++) begin
         cfg(16'(16'h8000 | (m << 1)), 16'h0009);
         dn = 1'b0;
         repeat (12) begin
            rd(4'h1, q);
            dn |= q[15];
         end
         chk({15'h0000, dn}, 16'(m));
      end
      cfg(16'h8000, 16'h0003);
      wr(4'h2, 16'h0007);
      ev_gap(1'b0);
      chk(16'(g), 16'h0008);
      wr(4'h3, 16'h0002);
      ev_gap(1'b1);
      chk(16'(g), 16'h0008);
      wr(4'h3, 16'h8002);
      repeat (3) @(negedge mclk);
      n = 0;
      repeat (30) begin
         @(negedge mclk);
         n += int'(special_event_trigger);
      end
      chk(16'(n), 16'h0000);
      cfg(16'h8002, 16'h0007);
      ev_gap(1'b1);
      chk(16'(g), 16'h000e);
      cfg(16'h8000, 16'h0007);
      for (int u = 0; u < 2; u++) begin
         pm = 4'($random(seed));
         wr(4'h4, {4'h0, pm, 8'hff});
         wr(4'h5, u ? 16'h0000 : 16'h0004);
         for (int p = 0; p < 4; p++) begin
            du[p] = {$random(seed)} % 10;
            wr(4'(6 + p), 16'(du[p]));
            du[p] = du[p] > 8 ? 8 : du[p];
         end
         ev_gap(1'b0);
         ev_gap(1'b0);
         for (int p = 0; p < 4; p++) begin
            chk(16'(hi[p]), 16'(du[p]));
            chk(16'(lo[p]), 16'(pm[p] ? du[p] : 8 - du[p]));
         end
      end
      d = 16'($random(seed));
      wr(4'h4, 16'h00ff);
      wr(4'ha, {d[15:8], 8'hff});
      repeat (4) @(negedge mclk);
      chk({8'h00, high_output, low_output}, {8'h00, hb(d[15:8]), lb(d[15:8])});
      wr(4'ha, 16'h0000);
      wr(4'hb, {d[7:0], 8'h05});
      fault_cmd <= 1'b1;
      repeat (6) @(negedge mclk);
      chk({8'h00, high_output & 4'h5, low_output & 4'h5},
         {8'h00, hb(d[7:0]) & 4'h5, lb(d[7:0]) & 4'h5});
      rd(4'hc, q);
      chk(q & 16'h00f1, 16'h0051);
      @(posedge mclk);
      fault_cmd <= 1'b0;
      wr(4'hb, 16'h0000);
      wr(4'h4, 16'h0000);
      repeat (3) @(negedge mclk);
      chk({8'h00, high_output_oe_n, low_output_oe_n}, 16'h00ff);
      give_verdict();
   end
endmodule : motor_pwm_time_base_test
`default_nettype wire

// *** sim/power_stage_model.sv ***
`default_nettype none
module power_stage_model
   import motor_pwm_pkg::*;
(
   input wire logic fault_cmd,
   output logic fault_in_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // The trip line idles high on its pull-up and is pulled low while the stage trips.
   assign fault_in_n = !fault_cmd;
endmodule : power_stage_model
`default_nettype wire

// *** sim/pwm_output_asserts.sv ***
`default_nettype none
module pwm_output_checks
   import motor_pwm_pkg::*;
#(
   parameter int PAIRS = 4
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic fault_in_n,
   input wire logic pin_enable_strap,
   input wire logic [PAIRS-1:0] high_output,
   input wire logic [PAIRS-1:0] low_output,
   input wire logic [PAIRS-1:0] high_output_oe_n,
   input wire logic [PAIRS-1:0] low_output_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // ====================
   // Shadow state.
   logic [15:0] pair, ovr, flt;
   logic [1:0] quiet;
   logic [2:0] flow;
   logic [3:0] plain, om, fm;
   // Pick the high-side and the low-side bits out of a pair-ordered byte.
   function automatic logic [3:0] hb(input logic [7:0] x);
      hb = {x[7], x[5], x[3], x[1]};
   endfunction : hb
   function automatic logic [3:0] lb(input logic [7:0] x);
      lb = {x[6], x[4], x[2], x[0]};
   endfunction : lb
   // Copies of the registers that steer the pins, taken from the writes.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pair <= {8'h00, {8{pin_enable_strap}}};
         ovr <= 16'h0000;
         flt <= 16'h0000;
      end else if (reg_wr) begin
         case (reg_addr)
            4'h4: pair <= reg_wdata;
            4'ha: ovr <= reg_wdata;
            4'hb: flt <= reg_wdata;
            default: ;
         endcase
      end
   end
   // Cycles since the last write and since the fault pin fell.
   always_ff @(posedge mclk) begin
      quiet <= (!rst_n || reg_wr) ? 2'h0 : quiet + {1'b0, quiet != 2'h3};
      flow <= (!rst_n || fault_in_n) ? 3'h0 : flow + {2'h0, flow != 3'h5};
   end
   // Pairs fully enabled and running plain, overridden or under fault control.
   assign plain = pair[7:4] & pair[3:0] & ~hb(ovr[7:0]) & ~lb(ovr[7:0]) & ~flt[3:0];
   assign om = pair[7:4] & pair[3:0] & hb(ovr[7:0]) & lb(ovr[7:0]) & ~flt[3:0];
   assign fm = pair[7:4] & pair[3:0] & flt[3:0];
   AST_RDATA_IDLE: assert property (@(posedge mclk) disable iff (!rst_n)
      !$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("stray read data");
   AST_PERIOD_TOP: assert property (@(posedge mclk) disable iff (!rst_n)
      $past(reg_rd) && $past(reg_addr) == 4'h2 |-> !reg_rdata[15]) else $error("period top bit");
   AST_OE_MIRROR: assert property (@(posedge mclk) disable iff (!rst_n)
      quiet == 2'h3 |-> {high_output_oe_n, low_output_oe_n} == ~pair[7:0])
      else $error("enable mismatch");
   AST_RELEASED_LOW: assert property (@(posedge mclk) disable iff (!rst_n)
      ((high_output & high_output_oe_n) | (low_output & low_output_oe_n)) == 4'h0)
      else $error("released pin high");
   AST_COMPLEMENT: assert property (@(posedge mclk) disable iff (!rst_n)
      quiet == 2'h3 |-> ((high_output ~^ low_output) & plain & ~pair[11:8]) == 4'h0)
      else $error("pair not inverted");
   AST_INDEPENDENT: assert property (@(posedge mclk) disable iff (!rst_n)
      quiet == 2'h3 |-> ((high_output ^ low_output) & plain & pair[11:8]) == 4'h0)
      else $error("pair halves differ");
   AST_OVERRIDE: assert property (@(posedge mclk) disable iff (!rst_n)
      quiet == 2'h3 |-> (((high_output ^ hb(ovr[15:8])) | (low_output ^ lb(ovr[15:8]))) & om)
      == 4'h0) else $error("override missed");
   AST_FAULT: assert property (@(posedge mclk) disable iff (!rst_n)
      quiet == 2'h3 && flow == 3'h5 |-> (((high_output ^ hb(flt[15:8])) |
      (low_output ^ lb(flt[15:8]))) & fm) == 4'h0) else $error("fault state missed");
endmodule : pwm_output_checks
bind motor_pwm_time_base pwm_output_checks #(.PAIRS(PAIRS)) checks (.mclk(mclk), .rst_n(rst_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .fault_in_n(fault_in_n), .pin_enable_strap(pin_enable_strap),
   .high_output(high_output), .low_output(low_output), .high_output_oe_n(high_output_oe_n),
   .low_output_oe_n(low_output_oe_n));
`default_nettype wire
